// file: common/mode_arb_pkg.sv
// Constants and types shared by the operation mode arbiter.
// Assumes one 50 MHz clock and synchronous active-high reset.
package mode_arb_pkg;

	// Operation modes, one-hot
	typedef enum logic [2:0] {
		MODE_PANEL   = 3'h1,
		MODE_CONTACT = 3'h2,
		MODE_SERIAL  = 3'h4
	} op_mode_t;

	localparam op_mode_t MODE_RST = MODE_PANEL;

	// Display indication codes
	localparam logic [1:0] DISP_PANEL      = 2'h0;
	localparam logic [1:0] DISP_CONTACT    = 2'h1;
	localparam logic [1:0] DISP_SERIAL     = 2'h2;
	localparam logic [1:0] DISP_SERIAL_RUN = 2'h3;

	// Analog source selection codes
	localparam logic [1:0] ASRC_TEMP1 = 2'h0;
	localparam logic [1:0] ASRC_TEMP2 = 2'h1;
	localparam logic [1:0] ASRC_COND  = 2'h2;

	// Reset values
	localparam logic       RUN_RST      = 1'h0;
	localparam logic [15:0] SETPT_RST   = 16'h0000;
	localparam logic       LVL_RST      = 1'h0;

	localparam int SETPT_W = 16;
	localparam int ANA_W   = 16;
	localparam int NSRC    = 3;

endpackage

// file: hdl/contact_input_cond.sv
// Conditions one contact input: polarity and alternate/momentary form.
// Assumes the input is already synchronous to ref_clk_i.
`timescale 1ns/10ps
module contact_input_cond (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Configuration
	input  wire logic nc_type_i,
	input  wire logic momentary_i,
	// Contact
	input  wire logic raw_i,
	// Result
	output logic      level_o,
	output logic      rise_o
);

	typedef struct packed {
		logic prev;
		logic toggle;
		logic level;
		logic rise;
	} cond_state_t;

	cond_state_t st_r;
	cond_state_t st_nxt;
	logic        act;

	always_comb begin
		act = raw_i ^ nc_type_i;
		st_nxt = st_r;
		st_nxt.prev = act;
		st_nxt.rise = act & ~st_r.prev;
		// Momentary pulses toggle a held state; alternate follows the level
		if (momentary_i) begin
			if (act & ~st_r.prev) begin
				st_nxt.toggle = ~st_r.toggle;
			end
			st_nxt.level = st_nxt.toggle;
		end else begin
			st_nxt.toggle = act;
			st_nxt.level = act;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			// Seed the history so an idle closed contact gives no edge
			st_r.prev <= raw_i ^ nc_type_i;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_o = st_r.level;
	assign rise_o  = st_r.rise;

endmodule

// file: hdl/operation_mode_arbiter.sv
// Operation mode arbiter: holds the mode and gates run/stop and setpoint.
// Assumes all inputs synchronous to ref_clk_i; command strobes one cycle.
//
// Functional notes
// - Reset selects panel mode.
// - Panel mode: panel alone commands run and setpoint.
// - Contact mode: contact run, panel setpoint, serial rejected.
// - Serial mode: serial alone commands run and setpoint.
// - Serial with contact option: contact run, serial setpoint.
// - Other settings and status reading always allowed.
// - Mode requests act only on rising edge.
// - Contact input three rising enters contact mode.
// - Serial flag rising enters serial mode.
// - Only panel action returns to panel mode.
// - Contact input three is mode request only.
// - Inputs one, two: form and polarity configurable.
// - Outputs one to three fixed, polarity selectable.
// - Outputs four to six selectable signal, polarity.
// - Analog outputs choose among three quantities.
// - Display shows mode, serial-contact-run distinct.
// - Outside contact mode contact run ignored, except serial mode with contact option.
`timescale 1ns/10ps
module operation_mode_arbiter (
	// Clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_i,
	// Touch panel commands
	input  wire logic                   panel_run_i,
	input  wire logic                   panel_stop_i,
	input  wire logic                   panel_setpt_we_i,
	input  wire logic [15:0]            panel_setpt_i,
	input  wire logic                   panel_mode_we_i,
	input  wire logic                   panel_settings_we_i,
	// Serial host commands
	input  wire logic                   serial_run_i,
	input  wire logic                   serial_stop_i,
	input  wire logic                   serial_setpt_we_i,
	input  wire logic [15:0]            serial_setpt_i,
	input  wire logic                   serial_mode_req_i,
	// Contact inputs
	input  wire logic [2:0]             contact_in_i,
	// Configuration, written from the panel settings screens
	input  wire logic                   contact_run_option_i,
	input  wire logic [1:0]             in_nc_type_i,
	input  wire logic [1:0]             in_momentary_i,
	input  wire logic [5:0]             out_nc_type_i,
	input  wire logic [8:0]             out_sel_i,
	input  wire logic [3:0]             ana_sel_i,
	// Equipment status
	input  wire logic                   stopping_fault_alarm_i,
	input  wire logic                   continue_warning_alarm_i,
	input  wire logic [7:0]             status_flags_i,
	input  wire logic [15:0]            ana_temp1_i,
	input  wire logic [15:0]            ana_temp2_i,
	input  wire logic [15:0]            ana_cond_i,
	// Mode and command results
	output logic [2:0]                  mode_o,
	output logic [1:0]                  display_o,
	output logic                        run_o,
	output logic [15:0]                 setpt_o,
	output logic                        ext_switch_o,
	output logic                        settings_we_o,
	// Contact and analog outputs
	output logic [5:0]                  contact_out_o,
	output logic [15:0]                 ana_out1_o,
	output logic [15:0]                 ana_out2_o
);

	typedef struct packed {
		mode_arb_pkg::op_mode_t mode;
		logic                   req3_prev;
		logic                   req3_sync;
		logic                   sreq_prev;
		logic                   run_in_prev;
		logic                   run;
		logic [15:0]            setpt;
		logic [1:0]             display;
		logic [5:0]             cout;
		logic [15:0]            a1;
		logic [15:0]            a2;
		logic                   ext_sw;
		logic                   set_we;
	} arb_state_t;

	arb_state_t st_r;
	arb_state_t st_nxt;

	logic run_lvl;
	logic sw_lvl;
	logic contact_run_ok;
	logic panel_run_ok;
	logic serial_run_ok;
	logic panel_sp_ok;
	logic serial_sp_ok;
	logic run_prev_lvl;

	// Selects an analog source among the three quantities
	function automatic logic [15:0] ana_pick(input logic [1:0] sel,
		input logic [15:0] t1, input logic [15:0] t2,
		input logic [15:0] c);
		case (sel)
			mode_arb_pkg::ASRC_TEMP1: ana_pick = t1;
			mode_arb_pkg::ASRC_TEMP2: ana_pick = t2;
			mode_arb_pkg::ASRC_COND:  ana_pick = c;
			default:                  ana_pick = t1;
		endcase
	endfunction

	// Selects a status flag for a configurable contact output
	function automatic logic flag_pick(input logic [2:0] sel,
		input logic [7:0] flags);
		flag_pick = flags[sel];
	endfunction

	contact_input_cond u_in_run (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.nc_type_i   (in_nc_type_i[0]),
		.momentary_i (in_momentary_i[0]),
		.raw_i       (contact_in_i[0]),
		.level_o     (run_lvl),
		.rise_o      ()
	);

	contact_input_cond u_in_sw (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.nc_type_i   (in_nc_type_i[1]),
		.momentary_i (in_momentary_i[1]),
		.raw_i       (contact_in_i[1]),
		.level_o     (sw_lvl),
		.rise_o      ()
	);

	always_comb begin
		contact_run_ok = (st_r.mode == mode_arb_pkg::MODE_CONTACT) |
			((st_r.mode == mode_arb_pkg::MODE_SERIAL) &
			contact_run_option_i);
		panel_run_ok = (st_r.mode == mode_arb_pkg::MODE_PANEL);
		serial_run_ok = (st_r.mode == mode_arb_pkg::MODE_SERIAL) &
			~contact_run_option_i;
		panel_sp_ok = (st_r.mode == mode_arb_pkg::MODE_PANEL) |
			(st_r.mode == mode_arb_pkg::MODE_CONTACT);
		serial_sp_ok = (st_r.mode == mode_arb_pkg::MODE_SERIAL);
		run_prev_lvl = st_r.run_in_prev;
	end

	always_comb begin
		st_nxt = st_r;
		// Input three is a bare momentary request; no configuration applies
		st_nxt.req3_sync = contact_in_i[2];
		st_nxt.req3_prev = st_r.req3_sync;
		st_nxt.sreq_prev = serial_mode_req_i;
		st_nxt.run_in_prev = run_lvl;

		// Mode: if both rise together, contact wins, as its edge is seen one cycle after the serial edge
		if (panel_mode_we_i) begin
			st_nxt.mode = mode_arb_pkg::MODE_PANEL;
		end else if (serial_mode_req_i & ~st_r.sreq_prev) begin
			st_nxt.mode = mode_arb_pkg::MODE_SERIAL;
		end else if (st_r.req3_sync & ~st_r.req3_prev) begin
			st_nxt.mode = mode_arb_pkg::MODE_CONTACT;
		end

		// Run/stop from the authorised source only; others dropped
		if (panel_run_ok) begin
			if (panel_stop_i) begin
				st_nxt.run = 1'b0;
			end else if (panel_run_i) begin
				st_nxt.run = 1'b1;
			end
		end else if (serial_run_ok) begin
			if (serial_stop_i) begin
				st_nxt.run = 1'b0;
			end else if (serial_run_i) begin
				st_nxt.run = 1'b1;
			end
		end else if (contact_run_ok) begin
			// Contact run level is applied on change only
			if (run_lvl != run_prev_lvl) begin
				st_nxt.run = run_lvl;
			end
		end

		if (panel_sp_ok & panel_setpt_we_i) begin
			st_nxt.setpt = panel_setpt_i;
		end else if (serial_sp_ok & serial_setpt_we_i) begin
			st_nxt.setpt = serial_setpt_i;
		end

		case (st_nxt.mode)
			mode_arb_pkg::MODE_PANEL: begin
				st_nxt.display = mode_arb_pkg::DISP_PANEL;
			end
			mode_arb_pkg::MODE_CONTACT: begin
				st_nxt.display = mode_arb_pkg::DISP_CONTACT;
			end
			mode_arb_pkg::MODE_SERIAL: begin
				st_nxt.display = contact_run_option_i ?
					mode_arb_pkg::DISP_SERIAL_RUN :
					mode_arb_pkg::DISP_SERIAL;
			end
			default: begin
				st_nxt.display = mode_arb_pkg::DISP_PANEL;
			end
		endcase

		// Status outputs run in every mode
		st_nxt.cout[0] = st_r.run ^ out_nc_type_i[0];
		st_nxt.cout[1] = stopping_fault_alarm_i ^ out_nc_type_i[1];
		st_nxt.cout[2] = continue_warning_alarm_i ^ out_nc_type_i[2];
		for (int i = 0; i < 3; i++) begin
			st_nxt.cout[3 + i] = flag_pick(out_sel_i[3 * i +: 3],
				status_flags_i) ^ out_nc_type_i[3 + i];
		end

		st_nxt.a1 = ana_pick(ana_sel_i[1:0], ana_temp1_i, ana_temp2_i,
			ana_cond_i);
		st_nxt.a2 = ana_pick(ana_sel_i[3:2], ana_temp1_i, ana_temp2_i,
			ana_cond_i);
		st_nxt.ext_sw = sw_lvl;
		st_nxt.set_we = panel_settings_we_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.mode <= mode_arb_pkg::MODE_RST;
			st_r.run <= mode_arb_pkg::RUN_RST;
			st_r.setpt <= mode_arb_pkg::SETPT_RST;
			st_r.display <= mode_arb_pkg::DISP_PANEL;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mode_o        = st_r.mode;
	assign display_o     = st_r.display;
	assign run_o         = st_r.run;
	assign setpt_o       = st_r.setpt;
	assign ext_switch_o  = st_r.ext_sw;
	assign settings_we_o = st_r.set_we;
	assign contact_out_o = st_r.cout;
	assign ana_out1_o    = st_r.a1;
	assign ana_out2_o    = st_r.a2;

endmodule

// file: testbench/mode_arb_props.sv
// Checker for the operation mode arbiter, bound to its ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
module mode_arb_props (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        panel_run_i,
	input wire logic        panel_stop_i,
	input wire logic        panel_mode_we_i,
	input wire logic        panel_settings_we_i,
	input wire logic        serial_mode_req_i,
	input wire logic        serial_setpt_we_i,
	input wire logic [15:0] serial_setpt_i,
	input wire logic [2:0]  contact_in_i,
	input wire logic [2:0]  mode_o,
	input wire logic [1:0]  display_o,
	input wire logic        run_o,
	input wire logic [15:0] setpt_o,
	input wire logic        settings_we_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_c_rise;
		!contact_in_i[2] ##1 contact_in_i[2];
	endsequence
	property p_rst;
		$fell(rst_i) |-> mode_o == 3'h1 && !run_o && setpt_o == 16'h0000;
	endproperty
	property p_ser;
		$rose(serial_mode_req_i) && !panel_mode_we_i |=> mode_o == 3'h4;
	endproperty
	property p_cnt;
		s_c_rise |-> ##3 mode_o == 3'h2;
	endproperty
	property p_pnl;
		panel_mode_we_i |=> mode_o == 3'h1;
	endproperty
	property p_keep;
		mode_o != 3'h1 && !panel_mode_we_i |=> mode_o != 3'h1;
	endproperty
	property p_held;
		mode_o == 3'h1 && serial_mode_req_i && $past(serial_mode_req_i)
			&& !$past(contact_in_i[2], 2) |=> mode_o == 3'h1;
	endproperty
	property p_run;
		mode_o == 3'h1 && panel_run_i && !panel_stop_i |=> run_o;
	endproperty
	property p_prej;
		mode_o == 3'h1 && !panel_run_i && !panel_stop_i
			|=> $stable(run_o) || mode_o != 3'h1;
	endproperty
	property p_sset;
		mode_o == 3'h4 && serial_setpt_we_i
			|=> setpt_o == $past(serial_setpt_i);
	endproperty
	property p_srej;
		mode_o == 3'h2 && serial_setpt_we_i |=> $stable(setpt_o);
	endproperty
	property p_disp;
		mode_o == 3'h2 |-> display_o == 2'h1;
	endproperty
	property p_swe;
		panel_settings_we_i |=> settings_we_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset");
	a_ser: assert property (p_ser) else $error("no serial");
	a_cnt: assert property (p_cnt) else $error("no contact");
	a_pnl: assert property (p_pnl) else $error("no panel");
	a_keep: assert property (p_keep) else $error("left");
	a_held: assert property (p_held) else $error("held");
	a_run: assert property (p_run) else $error("no run");
	a_prej: assert property (p_prej) else $error("run");
	a_sset: assert property (p_sset) else $error("setpt");
	a_srej: assert property (p_srej) else $error("took");
	a_disp: assert property (p_disp) else $error("display");
	a_swe: assert property (p_swe) else $error("settings");
endmodule
bind operation_mode_arbiter mode_arb_props u_props (.*);

// file: testbench/customer_ctl.sv
// Customer system model: drives the contacts and the serial mode flag.
// Assumes calls begin after reset; drives at the rising clock edge.
`timescale 1ns/10ps
module customer_ctl (
	input  wire logic ref_clk_i,
	output logic [2:0] contact_o,
	output logic       ser_req_o
);
	initial contact_o = 3'h0;
	initial ser_req_o = 1'h0;
	task automatic mode_press();
		@(posedge ref_clk_i);
		contact_o[2] <= 1'h1;
		repeat (4) @(posedge ref_clk_i);
		contact_o[2] <= 1'h0;
	endtask
	task automatic run_lvl(input logic v);
		@(posedge ref_clk_i);
		contact_o[0] <= v;
	endtask
	task automatic ser_flag(input logic v);
		@(posedge ref_clk_i);
		ser_req_o <= v;
	endtask
endmodule

// file: testbench/operation_mode_arbiter_tb.sv
// Bench for the operation mode arbiter: mode changes, command gating.
// Assumes the customer model drives the contacts and the serial flag.
`timescale 1ns/10ps
module operation_mode_arbiter_tb;
	logic        ref_clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [7:0]  stb = 8'h00;
	logic [15:0] sv = 16'h0000;
	logic        opt = 1'h0;
	logic        stopping_fault_alarm = 1'h0;
	logic [5:0]  onc = 6'h00;
	logic [3:0]  asel = 4'h0;
	logic [1:0]  inc = 2'h0;
	logic [1:0]  imom = 2'h0;
	logic [8:0]  osel = 9'h000;
	logic [7:0]  sflg = 8'h00;
	logic        continue_warning_alarm = 1'h0;
	logic        extsw;
	logic        swe;
	logic [15:0] av [4] = '{16'h0101, 16'h0202, 16'h0303, 16'h0101};
	logic [2:0]  cin;
	logic        sreq;
	logic [2:0]  mode;
	logic [1:0]  disp;
	logic        run;
	logic [15:0] setpt;
	logic [5:0]  cout;
	logic [15:0] a1;
	logic [15:0] a2;
	int          n_mismatch = 0;
	int          n_compared = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	customer_ctl pe (.ref_clk_i(ref_clk_i), .contact_o(cin), .ser_req_o(sreq));
	operation_mode_arbiter dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.panel_run_i(stb[0]), .panel_stop_i(stb[1]),
		.panel_setpt_we_i(stb[2]), .panel_setpt_i(sv),
		.panel_mode_we_i(stb[3]), .panel_settings_we_i(stb[4]),
		.serial_run_i(stb[5]), .serial_stop_i(stb[6]),
		.serial_setpt_we_i(stb[7]), .serial_setpt_i(sv),
		.serial_mode_req_i(sreq), .contact_in_i(cin),
		.contact_run_option_i(opt), .in_nc_type_i(inc),
		.in_momentary_i(imom), .out_nc_type_i(onc), .out_sel_i(osel),
		.ana_sel_i(asel), .stopping_fault_alarm_i(stopping_fault_alarm),
		.continue_warning_alarm_i(continue_warning_alarm), .status_flags_i(sflg),
		.ana_temp1_i(av[0]), .ana_temp2_i(av[1]), .ana_cond_i(av[2]),
		.mode_o(mode), .display_o(disp), .run_o(run), .setpt_o(setpt),
		.ext_switch_o(extsw), .settings_we_o(swe), .contact_out_o(cout),
		.ana_out1_o(a1), .ana_out2_o(a2));
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic w(input int n);
		cy(n);
		#1;
	endtask
	task automatic pulse(input int i, input logic [15:0] v);
		@(posedge ref_clk_i);
		stb[i] <= 1'h1;
		sv <= v;
		@(posedge ref_clk_i);
		stb <= 8'h00;
		#1;
	endtask
	task automatic toggle();
		pe.run_lvl(1'h1);
		cy(4);
		pe.run_lvl(1'h0);
		w(4);
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cy(8);
		rst_i <= 1'h0;
		w(1);
		chk({disp, run, mode}, 16'h0001);
		cy(1);
		inc <= 2'h2;
		w(2);
		chk(extsw, 16'h0001);
		pulse(2, 16'h1234);
		chk(setpt, 16'h1234);
		pulse(7, 16'h0BAD);
		chk(setpt, 16'h1234);
		pulse(5, 16'h0000);
		chk(run, 16'h0000);
		pulse(0, 16'h0000);
		chk(run, 16'h0001);
		toggle();
		chk(run, 16'h0001);
		pulse(4, 16'h0000);
		chk(swe, 16'h0001);
		cy(1);
		stopping_fault_alarm <= 1'h1;
		onc <= 6'h04;
		w(3);
		chk(cout[2:0], 16'h0007);
		cy(1);
		continue_warning_alarm <= 1'h1;
		sflg <= 8'h20;
		osel <= 9'h1E8;
		w(2);
		chk(cout[2:0], 16'h0003);
		chk(cout[5:3], 16'h0002);
		pe.mode_press();
		w(0);
		chk({disp, mode}, 16'h000A);
		toggle();
		chk(run, 16'h0000);
		cy(1);
		imom <= 2'h1;
		w(1);
		toggle();
		chk(run, 16'h0001);
		cy(1);
		imom <= 2'h0;
		w(2);
		chk(run, 16'h0000);
		pulse(0, 16'h0000);
		chk(run, 16'h0000);
		pulse(7, 16'h0BAD);
		chk(setpt, 16'h1234);
		pulse(2, 16'h2345);
		chk(setpt, 16'h2345);
		pe.ser_flag(1'h1);
		w(1);
		chk({disp, mode}, 16'h0014);
		pulse(2, 16'h3456);
		chk(setpt, 16'h2345);
		pulse(7, 16'h4567);
		chk(setpt, 16'h4567);
		pulse(5, 16'h0000);
		chk(run, 16'h0001);
		pulse(1, 16'h0000);
		chk(run, 16'h0001);
		toggle();
		chk(run, 16'h0001);
		cy(1);
		opt <= 1'h1;
		w(2);
		chk(disp, 16'h0003);
		toggle();
		chk(run, 16'h0000);
		pulse(7, 16'h5678);
		chk(setpt, 16'h5678);
		pulse(5, 16'h0000);
		chk(run, 16'h0000);
		pulse(3, 16'h0000);
		w(4);
		chk(mode, 16'h0001);
		pe.ser_flag(1'h0);
		pe.ser_flag(1'h1);
		w(1);
		chk(mode, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			cy(1);
			asel <= {k[1:0], k[1:0]};
			w(2);
			chk(a1, av[k]);
			chk(a2, av[k]);
		end
		final_report();
	end
endmodule
